// ==== shared/lfds_pkg.sv ====
// Shared constants, types and register map of the LED fault detection sequencer
package lfds_pkg;

  localparam int NUM_CH = 8;
  localparam int GROUP_SIZE = 4;
  localparam int IMG_BITS = 8;
  localparam int CMD_BITS = 10;
  localparam int FLAG_BITS = 3;

  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int STAGGER_NS = 3;
  localparam int STAGGER_RAW = (STAGGER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAGGER_CYC = (STAGGER_RAW < 1) ? 1 : STAGGER_RAW;

  // Clock-edge counts decoded at the strobe falling edge; CNT_MAX is where the count saturates
  localparam logic [2:0] CNT_OPEN = 3'h1;
  localparam logic [2:0] CNT_GND = 3'h2;
  localparam logic [2:0] CNT_SHORT = 3'h3;
  localparam logic [2:0] CNT_CMD = 3'h4;
  localparam logic [2:0] CNT_MAX = 3'h7;

  // Wishbone register map (byte addresses)
  localparam int ADR_W = 8;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_CMD = 8'h08;
  localparam int CTRL_DET_EN = 0;
  localparam int CTRL_FORCE_OFF = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int ST_IMG_LSB = 0;
  localparam int ST_REP_LSB = 8;
  localparam int ST_FLAG_LSB = 16;
  localparam int ST_MODE_BIT = 19;
  localparam int ST_TYPE_LSB = 20;

  // Command word power-on values
  localparam logic [6:0] GBC_RESET = 7'h40;
  localparam logic [1:0] SV_RESET = 2'h2;
  localparam logic SLP_RESET = 1'b0;

  typedef enum logic [2:0] {
    DET_NONE = 3'b000,
    DET_RT_OPEN = 3'b001,
    DET_RT_GND = 3'b010,
    DET_RT_SHORT = 3'b011,
    DET_SM_OPEN = 3'b101,
    DET_SM_GND = 3'b110,
    DET_SM_SHORT = 3'b111
  } lfds_det_e;

  typedef enum logic [1:0] {
    ST_IMAGE = 2'b00,
    ST_ARMED = 2'b01,
    ST_SMART = 2'b10,
    ST_CMD = 2'b11
  } lfds_state_e;

  typedef struct packed {
    logic hot;
    logic crit;
    logic shut;
  } lfds_therm_s;

  typedef struct packed {
    logic [6:0] gbc;
    logic [1:0] sv;
    logic slp;
  } lfds_cmd_s;

endpackage

// ==== src/lfds_top.sv ====
// LED fault detection sequencer: serial link, detection decode, thermal flags, staggered sinks
module lfds_top #(
  parameter int NUM_CH = lfds_pkg::NUM_CH,
  parameter int GROUP_SIZE = lfds_pkg::GROUP_SIZE
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Serial link pins
  input wire logic shift_clk_pin,
  input wire logic strobe_pin,
  input wire logic serial_in_pin,
  input wire logic enable_n_pin,
  output logic serial_return_pin,
  // Analog sense inputs
  input wire logic [NUM_CH-1:0] ch_conducting,
  input wire logic [NUM_CH-1:0] ch_below_low,
  input wire logic [NUM_CH-1:0] ch_above_supply,
  input wire logic temp_over_130,
  input wire logic temp_over_170,
  // Output drive
  output logic [NUM_CH-1:0] sink_channels,
  output logic [NUM_CH-1:0] sink_weak_on,
  output logic [NUM_CH-1:0] sink_pull_high,
  output lfds_pkg::lfds_therm_s therm_flags,
  output lfds_pkg::lfds_cmd_s cmd_word,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [lfds_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  localparam int PIPE_DEPTH = GROUP_SIZE * lfds_pkg::STAGGER_CYC;

  lfds_pkg::lfds_state_e state_reg;
  lfds_pkg::lfds_det_e det_reg;
  lfds_pkg::lfds_det_e last_det_reg;
  logic [2:0] cnt_reg;
  logic [lfds_pkg::CMD_BITS-1:0] shreg_reg;
  logic [NUM_CH-1:0] img_reg;
  logic [NUM_CH-1:0] report_reg;
  logic sclk_d_reg;
  logic strobe_d_reg;
  logic [1:0] ctrl_reg;
  logic [NUM_CH-1:0] target_reg;
  logic [NUM_CH-1:0] pipe_reg [0:PIPE_DEPTH];

  wire logic clk_rise = shift_clk_pin & ~sclk_d_reg;
  wire logic strobe_rise = strobe_pin & ~strobe_d_reg;
  wire logic strobe_fall = ~strobe_pin & strobe_d_reg;
  wire logic det_en = ctrl_reg[lfds_pkg::CTRL_DET_EN];
  wire logic out_en = ~enable_n_pin;

  // Real-time and smart result vectors
  logic [NUM_CH-1:0] rt_open, rt_gnd, rt_short, sm_open, sm_gnd, sm_short;
  assign rt_open = img_reg & {NUM_CH{out_en}} & ch_conducting & ch_below_low;
  assign rt_short = img_reg & {NUM_CH{out_en}} & ch_above_supply;
  assign rt_gnd = ~img_reg & ch_below_low;
  // Enable pin is not part of any smart result
  assign sm_open = ch_conducting & ch_below_low;
  assign sm_short = ch_conducting & ch_above_supply;
  assign sm_gnd = ch_below_low;

  logic [NUM_CH-1:0] rt_vec;
  logic [NUM_CH-1:0] sm_vec;
  lfds_pkg::lfds_det_e rt_type;
  always_comb begin
    rt_vec = '0;
    rt_type = lfds_pkg::DET_NONE;
    case (cnt_reg)
      lfds_pkg::CNT_OPEN: begin
        rt_vec = rt_open;
        rt_type = lfds_pkg::DET_RT_OPEN;
      end
      lfds_pkg::CNT_GND: begin
        rt_vec = rt_gnd;
        rt_type = lfds_pkg::DET_RT_GND;
      end
      lfds_pkg::CNT_SHORT: begin
        rt_vec = rt_short;
        rt_type = lfds_pkg::DET_RT_SHORT;
      end
      default: begin
        rt_vec = '0;
        rt_type = lfds_pkg::DET_NONE;
      end
    endcase
    case (det_reg)
      lfds_pkg::DET_SM_OPEN: sm_vec = sm_open;
      lfds_pkg::DET_SM_GND: sm_vec = sm_gnd;
      lfds_pkg::DET_SM_SHORT: sm_vec = sm_short;
      default: sm_vec = '0;
    endcase
  end

  // Pin edge history; inputs are already synchronous to ref_clk
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_d_reg <= 1'b0;
      strobe_d_reg <= 1'b0;
    end else if (clk_en) begin
      sclk_d_reg <= shift_clk_pin;
      strobe_d_reg <= strobe_pin;
    end
  end

  // Sequencer: shifting, latching, detection decode, command mode
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= lfds_pkg::ST_IMAGE;
      det_reg <= lfds_pkg::DET_NONE;
      last_det_reg <= lfds_pkg::DET_NONE;
      cnt_reg <= '0;
      shreg_reg <= '0;
      img_reg <= '0;
      report_reg <= '0;
      cmd_word <= {lfds_pkg::GBC_RESET, lfds_pkg::SV_RESET, lfds_pkg::SLP_RESET};
    end else if (clk_en) begin
      if (clk_rise && strobe_pin && cnt_reg != lfds_pkg::CNT_MAX) begin
        cnt_reg <= cnt_reg + 3'h1;
      end else if (strobe_rise) begin
        cnt_reg <= '0;
      end
      case (state_reg)
        lfds_pkg::ST_IMAGE: begin
          if (clk_rise && !strobe_pin) begin
            shreg_reg <= {shreg_reg[lfds_pkg::CMD_BITS-2:0], serial_in_pin};
          end else if (strobe_rise) begin
            img_reg <= shreg_reg[NUM_CH-1:0];
          end else if (strobe_fall && cnt_reg == lfds_pkg::CNT_CMD) begin
            // First three bits out are the thermal flags
            shreg_reg <= {therm_flags, 7'h00};
            state_reg <= lfds_pkg::ST_CMD;
          end else if (strobe_fall && det_en && rt_type != lfds_pkg::DET_NONE) begin
            // Real-time report replaces the echo; the image latch is untouched
            shreg_reg[NUM_CH-1:0] <= rt_vec;
            report_reg <= rt_vec;
            last_det_reg <= rt_type;
            det_reg <= rt_type;
            if (shift_clk_pin) begin
              state_reg <= lfds_pkg::ST_ARMED;
            end
          end
        end
        lfds_pkg::ST_ARMED: begin
          if (clk_rise) begin
            state_reg <= lfds_pkg::ST_IMAGE;
          end else if (strobe_fall && shift_clk_pin) begin
            det_reg <= lfds_pkg::lfds_det_e'({1'b1, det_reg[1:0]});
            state_reg <= lfds_pkg::ST_SMART;
          end
        end
        lfds_pkg::ST_SMART: begin
          if (clk_rise) begin
            shreg_reg[NUM_CH-1:0] <= sm_vec;
            report_reg <= sm_vec;
            last_det_reg <= det_reg;
            det_reg <= lfds_pkg::DET_NONE;
            state_reg <= lfds_pkg::ST_IMAGE;
          end
        end
        lfds_pkg::ST_CMD: begin
          if (clk_rise && !strobe_pin) begin
            shreg_reg <= {shreg_reg[lfds_pkg::CMD_BITS-2:0], serial_in_pin};
          end else if (strobe_rise) begin
            cmd_word <= shreg_reg;
            state_reg <= lfds_pkg::ST_IMAGE;
          end
        end
        default: state_reg <= lfds_pkg::ST_IMAGE;
      endcase
    end
  end

  // Return pin follows the top of the active shift width
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      serial_return_pin <= 1'b0;
    end else if (clk_en) begin
      serial_return_pin <= (state_reg == lfds_pkg::ST_CMD) ?
                           shreg_reg[lfds_pkg::CMD_BITS-1] : shreg_reg[NUM_CH-1];
    end
  end

  // Thermal flags; shutdown holds until the die is back under the alarm level
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      therm_flags <= '0;
    end else if (clk_en) begin
      therm_flags.hot <= temp_over_130;
      therm_flags.crit <= temp_over_170;
      if (temp_over_170) begin
        therm_flags.shut <= 1'b1;
      end else if (!temp_over_130) begin
        therm_flags.shut <= 1'b0;
      end
    end
  end

  // Output drive targets
  wire logic smart_on = (state_reg == lfds_pkg::ST_SMART);
  wire logic smart_gnd = smart_on && det_reg == lfds_pkg::DET_SM_GND;
  wire logic all_off = therm_flags.shut | cmd_word.slp | ctrl_reg[lfds_pkg::CTRL_FORCE_OFF];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      target_reg <= '0;
      sink_weak_on <= '0;
      sink_pull_high <= '0;
    end else if (clk_en) begin
      target_reg <= (all_off || smart_on) ? '0 : img_reg & {NUM_CH{out_en}};
      sink_weak_on <= (smart_on && !smart_gnd) ? '1 : '0;
      sink_pull_high <= smart_gnd ? '1 : '0;
    end
  end

  // Stagger pipe: shutdown bypasses it so every output drops at once
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int k = 0; k <= PIPE_DEPTH; k++) begin
        pipe_reg[k] <= '0;
      end
    end else if (clk_en) begin
      pipe_reg[0] <= target_reg;
      for (int k = 1; k <= PIPE_DEPTH; k++) begin
        pipe_reg[k] <= pipe_reg[k-1];
      end
    end
  end

  // One tap per channel, so the output register has a single process behind it
  wire logic [NUM_CH-1:0] stagger_tap;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      localparam int TAP = (gi % GROUP_SIZE) * lfds_pkg::STAGGER_CYC;
      assign stagger_tap[gi] = pipe_reg[TAP][gi];
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sink_channels <= '0;
    end else if (clk_en) begin
      sink_channels <= target_reg & stagger_tap;
    end
  end

  // Wishbone slave, one wait state, unmapped reads return zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      ctrl_reg <= lfds_pkg::CTRL_RESET;
    end else if (clk_en) begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= '0;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        case (wb_adr_i)
          lfds_pkg::ADR_CTRL: begin
            wb_dat_o[1:0] <= ctrl_reg;
            if (wb_we_i && wb_sel_i[0]) begin
              ctrl_reg <= wb_dat_i[1:0];
            end
          end
          lfds_pkg::ADR_STATUS: begin
            wb_dat_o[lfds_pkg::ST_IMG_LSB +: NUM_CH] <= img_reg;
            wb_dat_o[lfds_pkg::ST_REP_LSB +: NUM_CH] <= report_reg;
            wb_dat_o[lfds_pkg::ST_FLAG_LSB +: lfds_pkg::FLAG_BITS] <= therm_flags;
            wb_dat_o[lfds_pkg::ST_MODE_BIT] <= (state_reg == lfds_pkg::ST_CMD);
            wb_dat_o[lfds_pkg::ST_TYPE_LSB +: 3] <= last_det_reg;
          end
          lfds_pkg::ADR_CMD: wb_dat_o[lfds_pkg::CMD_BITS-1:0] <= cmd_word;
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_arm;
    clk_en && state_reg == lfds_pkg::ST_ARMED && strobe_fall && shift_clk_pin && !clk_rise;
  endsequence
  sequence s_smart_done;
    clk_en && smart_on && clk_rise;
  endsequence

  property p_rt_open;
    clk_en && state_reg == lfds_pkg::ST_IMAGE && strobe_fall && det_en && !clk_rise
      && cnt_reg == lfds_pkg::CNT_OPEN |=> shreg_reg[NUM_CH-1:0] == $past(rt_open);
  endproperty
  a_rt_open: assert property (p_rt_open) else $error("open report not loaded");

  property p_rt_keeps_image;
    clk_en && state_reg == lfds_pkg::ST_IMAGE && strobe_fall && cnt_reg != lfds_pkg::CNT_CMD
      |=> $stable(img_reg);
  endproperty
  a_rt_keeps_image: assert property (p_rt_keeps_image) else $error("image disturbed");

  property p_cmd_entry;
    clk_en && state_reg == lfds_pkg::ST_IMAGE && strobe_fall && cnt_reg == lfds_pkg::CNT_CMD
      && !clk_rise |=> state_reg == lfds_pkg::ST_CMD
      ##1 serial_return_pin == $past(therm_flags.hot, 2);
  endproperty
  a_cmd_entry: assert property (p_cmd_entry) else $error("command mode not entered");

  property p_smart_start;
    s_arm |=> smart_on && det_reg[2];
  endproperty
  a_smart_start: assert property (p_smart_start) else $error("smart not started");

  property p_smart_weak;
    clk_en && smart_on && !smart_gnd |=> sink_weak_on == '1 && target_reg == '0;
  endproperty
  a_smart_weak: assert property (p_smart_weak) else $error("weak drive missing");

  property p_smart_gnd;
    clk_en && smart_gnd |=> sink_pull_high == '1 && target_reg == '0;
  endproperty
  a_smart_gnd: assert property (p_smart_gnd) else $error("ground check drive wrong");

  property p_smart_end;
    s_smart_done |=> state_reg == lfds_pkg::ST_IMAGE && report_reg == $past(sm_vec);
  endproperty
  a_smart_end: assert property (p_smart_end) else $error("smart did not finish");

  property p_shutdown;
    (clk_en && therm_flags.shut) [*3] |-> sink_channels == '0;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("outputs on in shutdown");

  property p_recover;
    clk_en && therm_flags.shut && !temp_over_130 && !temp_over_170 |=> !therm_flags.shut;
  endproperty
  a_recover: assert property (p_recover) else $error("shutdown stuck");

  property p_flags_low;
    clk_en && !temp_over_130 && !temp_over_170 |=> therm_flags == '0;
  endproperty
  a_flags_low: assert property (p_flags_low) else $error("thermal flag set when cool");

endmodule

// ==== tb/lfds_ctrl_model.sv ====
// Display controller model: drives shift clock, strobe and data, reads the return line
module lfds_ctrl_model (
  // Clock
  input wire logic ref_clk,
  // Link pins
  output logic sclk,
  output logic strobe,
  output logic sdi,
  input wire logic sret,
  // Words read back
  output logic [9:0] rd_word,
  output logic rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk = 1'b0;
    strobe = 1'b0;
    sdi = 1'b0;
    rd_word = '0;
    rd_valid = 1'b0;
  end

  // Three cycles per level, above the one that the pin sampler needs
  task automatic hold();
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic clk(input logic v);
    sclk <= v;
    hold();
  endtask

  task automatic stb(input logic v);
    strobe <= v;
    hold();
  endtask

  // Bit k of the word is the k-th last clock counted, so a one there marks channel k
  task automatic shift(input int n, input logic [9:0] din, input bit keep);
    logic [9:0] d;
    d = '0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi <= din[i];
      hold();
      d[i] = sret;
      clk(1'b1);
      clk(1'b0);
    end
    if (keep) begin
      rd_word <= d;
      rd_valid <= 1'b1;
      @(posedge ref_clk);
      rd_valid <= 1'b0;
    end
  endtask
endmodule

// ==== tb/test_lfds_top.sv ====
// Self-checking bench of the LED fault detection sequencer
module test_lfds_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk, rstn, clk_en, enable_n_pin, temp_over_130, temp_over_170;
  logic shift_clk_pin, strobe_pin, serial_in_pin, serial_return_pin, rd_valid;
  logic [7:0] ch_conducting, ch_below_low, ch_above_supply;
  logic [7:0] sink_channels, sink_weak_on, sink_pull_high;
  logic [9:0] rd_word;
  lfds_pkg::lfds_therm_s therm_flags;
  lfds_pkg::lfds_cmd_s cmd_word;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [63:0] expq[$];
  int errors = 0;
  int cmp_count = 0;
  int seed = 31996;

  lfds_top i_lfds_top (.ref_clk, .rstn, .clk_en, .shift_clk_pin, .strobe_pin, .serial_in_pin,
    .enable_n_pin, .serial_return_pin, .ch_conducting, .ch_below_low, .ch_above_supply,
    .temp_over_130, .temp_over_170, .sink_channels, .sink_weak_on, .sink_pull_high,
    .therm_flags, .cmd_word, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o);

  lfds_ctrl_model i_lfds_ctrl_model (.ref_clk, .sclk(shift_clk_pin), .strobe(strobe_pin),
    .sdi(serial_in_pin), .sret(serial_return_pin), .rd_word, .rd_valid);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic note(input logic [31:0] m, input logic [31:0] v);
    expq.push_back({m, v});
  endtask

  task automatic take(input logic [31:0] got);
    logic [63:0] e;
    e = 64'hFFFF_FFFF_FFFF_FFFF;
    if (expq.size() > 0) begin
      e = expq.pop_front();
    end
    chk(got & e[63:32], e[31:0]);
  endtask

  // Results are matched in order against the notes left by the drivers
  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      take(wb_dat_o);
    end
    if (rd_valid === 1'b1) begin
      take({22'h0, rd_word});
    end
  end

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] m, input logic [31:0] v);
    note(m, v);
    wb(1'b0, adr, 32'h0);
  endtask

  task automatic lat(input logic v);
    i_lfds_ctrl_model.stb(v);
  endtask

  task automatic sck(input logic v);
    i_lfds_ctrl_model.clk(v);
  endtask

  function automatic logic [7:0] rep(input logic [2:0] c, input bit sm, input logic [7:0] im);
    logic [7:0] on;
    on = im & {8{~enable_n_pin}};
    case ({sm, c[1:0]})
      3'b001: rep = on & ch_conducting & ch_below_low;
      3'b010: rep = ~im & ch_below_low;
      3'b011: rep = on & ch_above_supply;
      3'b101: rep = ch_conducting & ch_below_low;
      3'b110: rep = ch_below_low;
      default: rep = ch_conducting & ch_above_supply;
    endcase
  endfunction

  task automatic frame(input logic [2:0] c, input bit sm);
    logic [7:0] img;
    logic [7:0] r;
    img = 8'($random(seed));
    r = rep(c, sm, img);
    i_lfds_ctrl_model.shift(8, {2'h0, img}, 1'b0);
    lat(1'b1);
    for (int k = 0; k < c; k++) begin
      sck(1'b1);
      if (!sm || k < c - 1) begin
        sck(1'b0);
      end
    end
    lat(1'b0);
    if (sm) begin
      lat(1'b1);
      lat(1'b0);
      chk(sink_weak_on, (c == 3'h2) ? 8'h00 : 8'hFF);
      chk(sink_pull_high, (c == 3'h2) ? 8'hFF : 8'h00);
      sck(1'b0);
      sck(1'b1);
      sck(1'b0);
      chk({sink_weak_on, sink_pull_high}, 16'h0);
    end
    note(32'hFF, r);
    i_lfds_ctrl_model.shift(8, 10'h0, 1'b1);
    rd(lfds_pkg::ADR_STATUS, sm ? 32'h0070_FF00 : 32'h0070_FFFF,
      {9'h0, sm, c[1:0], 4'h0, r, sm ? 8'h0 : img});
    if (!sm) begin
      chk(sink_channels, img & {8{~enable_n_pin}});
    end
  endtask

  task automatic cmd_frame(input logic [9:0] cmd, input logic [2:0] fl);
    lat(1'b1);
    repeat (4) begin
      sck(1'b1);
      sck(1'b0);
    end
    lat(1'b0);
    note(32'h3FF, {22'h0, fl, 7'h0});
    i_lfds_ctrl_model.shift(10, cmd, 1'b1);
    lat(1'b1);
    lat(1'b0);
    chk(cmd_word, cmd);
    rd(lfds_pkg::ADR_CMD, 32'h3FF, {22'h0, cmd});
  endtask

  task automatic load(input logic [7:0] img, input bit keep);
    i_lfds_ctrl_model.shift(8, {2'h0, img}, keep);
    lat(1'b1);
    lat(1'b0);
    repeat (8) @(posedge ref_clk);
  endtask

  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    enable_n_pin = 1'b0;
    temp_over_130 = 1'b0;
    temp_over_170 = 1'b0;
    ch_conducting = 8'h00;
    ch_below_low = 8'h00;
    ch_above_supply = 8'h00;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    chk(cmd_word, 10'h204);
    chk(therm_flags, 3'h0);
    rd(lfds_pkg::ADR_CTRL, 32'h3, 32'h1);
    rd(lfds_pkg::ADR_CMD, 32'h3FF, 32'h204);
    rd(8'h0C, 32'hFFFF_FFFF, 32'h0);
    rd(lfds_pkg::ADR_STATUS, 32'h000F_0000, 32'h0);
    $display("test registers done");
    load(8'hA5, 1'b0);
    note(32'hFF, 32'hA5);
    load(8'h3C, 1'b1);
    chk(sink_channels, 8'h3C);
    wb(1'b1, lfds_pkg::ADR_CTRL, 32'h3);
    @(posedge ref_clk);
    chk(sink_channels, 8'h00);
    wb(1'b1, lfds_pkg::ADR_CTRL, 32'h1);
    // Group heads come up first, one channel more per cycle inside each group
    repeat (2) @(posedge ref_clk);
    chk(sink_channels, 8'h10);
    @(posedge ref_clk);
    chk(sink_channels, 8'h30);
    repeat (8) @(posedge ref_clk);
    chk(sink_channels, 8'h3C);
    $display("test image done");
    repeat (10) begin
      ch_conducting <= 8'($random(seed));
      ch_below_low <= 8'($random(seed));
      ch_above_supply <= 8'($random(seed));
      enable_n_pin <= 1'($random(seed));
      @(posedge ref_clk);
      for (int c = 1; c <= 3; c++) begin
        frame(3'(c), 1'b0);
        frame(3'(c), 1'b1);
      end
    end
    $display("test detection done");
    enable_n_pin <= 1'b0;
    cmd_frame(10'h2A4, 3'h0);
    temp_over_130 <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(therm_flags, 3'h4);
    temp_over_170 <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(therm_flags, 3'h7);
    cmd_frame(10'h0FE, 3'h7);
    load(8'hF0, 1'b0);
    chk(sink_channels, 8'h00);
    temp_over_170 <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(therm_flags, 3'h5);
    chk(sink_channels, 8'h00);
    temp_over_130 <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(therm_flags, 3'h0);
    chk(sink_channels, 8'hF0);
    $display("test thermal done");
    cmd_frame(10'h0FF, 3'h0);
    chk(sink_channels, 8'h00);
    // Frozen block must ignore a hot die until the enable returns
    clk_en <= 1'b0;
    temp_over_130 <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(therm_flags, 3'h0);
    chk(sink_channels, 8'h00);
    clk_en <= 1'b1;
    temp_over_130 <= 1'b0;
    @(posedge ref_clk);
    $display("test sleep and freeze done");
    tally_and_finish();
  end

  // About five times the expected length of the run
  initial begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    tally_and_finish();
  end
endmodule
